// ==== inc/mbox_regs.svh ====
`ifndef MBOX_REGS_SVH
`define MBOX_REGS_SVH

// processor addresses, {cmd_xfer_sel, reg_b_sel}
`define ADDR_DATA_LOW     2'h0
`define ADDR_DATA_HIGH    2'h1
`define ADDR_CMD_LOW_BUSY 2'h2
`define ADDR_CMD_HIGH     2'h3

// busy flag position on a status read
`define BUSY_BIT          7

// reset values
`define MBOX_RESET        8'h00
`define WORD_RESET        16'h0000

// opcode field of a command word and the display mode load code
`define OPCODE_MSB        15
`define OPCODE_LSB        13
`define OPCODE_LOAD_MODE  3'h5

// highest decimal slice index
`define SLICE_MAX         4'h9

`endif

// ==== inc/mbox_pkg.sv ====
package mbox_pkg;

  typedef struct packed {
    logic       cs_n;
    logic       enable;
    logic       rw;
    logic       reg_b_sel;
    logic       cmd_xfer_sel;
    logic [7:0] data_in;
  } cpu_bus_t;

  typedef enum logic [1:0] {
    ENTRY_CMD,
    ENTRY_WRITE,
    ENTRY_READ
  } entry_kind_t;

  typedef struct packed {
    entry_kind_t kind;
    logic [15:0] word;
  } entry_t;

  typedef enum logic {
    SVC_IDLE,
    SVC_WAIT_FILL
  } svc_state_t;

endpackage

// ==== hdl/two_entry_buffer.sv ====
`timescale 1ns/100ps
module two_entry_buffer (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            resetn,
  // fill side
  input  wire logic            in_valid,
  output logic                 in_ready,
  input  wire mbox_pkg::entry_t in_entry,
  // drain side
  output logic                 out_valid,
  input  wire logic            out_ready,
  output mbox_pkg::entry_t     out_entry
);
  import mbox_pkg::*;

  typedef struct packed {
    entry_t [1:0] slot;
    logic   [1:0] count;
    logic         wr_ptr;
    logic         rd_ptr;
  } buf_state_t;

  buf_state_t s_reg;
  buf_state_t s_next;
  logic       push;
  logic       pop;

  assign in_ready  = (s_reg.count != 2'h2);
  assign out_valid = (s_reg.count != 2'h0);
  assign out_entry = s_reg.slot[s_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.slot[s_reg.wr_ptr] = in_entry;
      s_next.wr_ptr = !s_reg.wr_ptr;
    end
    if (pop) begin
      s_next.rd_ptr = !s_reg.rd_ptr;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 2'h1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 2'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// ==== hdl/display_mailbox_host_port.sv ====
// What this block does
// - request_strobe_n goes low on each permitted processor access to the upper register.
// - bus side latches cmd_xfer_sel at the strobe fall; the timing side copies it and keeps the request pending.
// - restart_n low forces hsync_out high until the display mode register loads.
// - data drivers are enabled only during a processor read of the unit.
// - four addresses answer only while chip select is low and enable high.
// - read/write low writes the mailbox, high reads it.
// - reg_b_sel zero picks the lower register, one the upper register.
// - cmd_xfer_sel high means command, low means data transfer; shared by both chips.
// - with chargen_strobe_n active, slice_addr gives the decimal slice index.
// - in data mode both registers read and write as one 16-bit word.
// - command mode writes a 16-bit command; low read gives busy; upper read illegal.
// - every permitted upper access sets busy and drives request_strobe_n low.
// - busy status appears on the top data bit; other bits carry no meaning.
// - the timing side reading a pending command out of the mailbox clears busy.
// - mbox_cycle_n selects the mailbox; internal_dir low source, high destination.
`timescale 1ns/100ps
`include "mbox_regs.svh"
module display_mailbox_host_port (
  // clocks and reset
  input  wire logic              clock,
  input  wire logic              bus_clock,
  input  wire logic              resetn,
  // processor bus pins
  input  wire mbox_pkg::cpu_bus_t cpu_in,
  output logic [7:0]             data_out,
  output logic                   data_oe,
  output logic                   request_strobe_n,
  // timing side control
  input  wire logic              restart_n,
  input  wire logic              line_sync_raw,
  output logic                   hsync_out,
  input  wire logic              bus_grant,
  output logic                   mbox_cycle_n,
  output logic                   internal_dir,
  // request words toward the access automaton
  output logic                   word_valid,
  input  wire logic              word_ready,
  output mbox_pkg::entry_t       word_out,
  // page memory data returned for a read transfer
  input  wire logic              fill_valid,
  input  wire logic [15:0]       fill_word,
  output logic                   fill_ready,
  // character generator slice address
  input  wire logic              chargen_strobe_n,
  input  wire logic [3:0]        slice_addr,
  output logic [3:0]             slice_index,
  output logic                   slice_valid
);
  import mbox_pkg::*;

  typedef struct packed {
    cpu_bus_t    pin_s1;
    cpu_bus_t    pin_s2;
    logic        access_prev;
    logic [7:0]  mailbox_low_byte;
    logic [7:0]  mailbox_high_byte;
    logic        busy;
    logic        req_strobe_n;
    logic [7:0]  data_out;
    logic        data_oe;
    logic        req_toggle;
    logic [15:0] req_word;
    logic        req_cmd;
    logic        req_read;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
  } bus_state_t;

  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_seen;
    logic        restart_s1;
    logic        restart_s2;
    logic        hold_high;
    logic        hsync;
    logic        pending;
    logic        pend_cmd;
    logic        pend_read;
    logic [15:0] pend_word;
    svc_state_t  state;
    logic        mbox_cycle_n;
    logic        internal_dir;
    logic        ack_toggle;
    logic        ack_load;
    logic [15:0] ack_word;
    logic [3:0]  slice_index;
    logic        slice_valid;
  } clk_state_t;

  bus_state_t b_reg;
  bus_state_t b_next;
  clk_state_t c_reg;
  clk_state_t c_next;

  logic       push;
  logic       buf_in_ready;
  entry_t     push_entry;
  logic       sel;
  logic       start;
  logic       upper;
  logic       illegal;
  logic [1:0] addr;
  logic       req_edge;
  logic       ack_edge;

  // processor bus domain, runs on the bus clock

  always_comb begin
    b_next = b_reg;
    b_next.pin_s1 = cpu_in;
    b_next.pin_s2 = b_reg.pin_s1;
    sel = !b_reg.pin_s2.cs_n && b_reg.pin_s2.enable;
    addr = {b_reg.pin_s2.cmd_xfer_sel, b_reg.pin_s2.reg_b_sel};
    illegal = (addr == `ADDR_CMD_HIGH) && b_reg.pin_s2.rw;
    upper = b_reg.pin_s2.reg_b_sel && !illegal;
    start = sel && !b_reg.access_prev;
    b_next.access_prev = sel;
    b_next.data_oe = sel && b_reg.pin_s2.rw && !illegal;
    unique case (addr)
      `ADDR_DATA_LOW: begin
        b_next.data_out = b_reg.mailbox_low_byte;
      end
      `ADDR_DATA_HIGH: begin
        b_next.data_out = b_reg.mailbox_high_byte;
      end
      `ADDR_CMD_LOW_BUSY: begin
        b_next.data_out = `MBOX_RESET;
        b_next.data_out[`BUSY_BIT] = b_reg.busy;
      end
      `ADDR_CMD_HIGH: begin
        b_next.data_out = `MBOX_RESET;
      end
    endcase
    ack_edge = (b_reg.ack_s2 != b_reg.ack_seen);
    b_next.ack_s1 = c_reg.ack_toggle;
    b_next.ack_s2 = b_reg.ack_s1;
    b_next.ack_seen = b_reg.ack_s2;
    if (ack_edge) begin
      b_next.busy = 1'b0;
      if (c_reg.ack_load) begin
        b_next.mailbox_low_byte = c_reg.ack_word[7:0];
        b_next.mailbox_high_byte = c_reg.ack_word[15:8];
      end
    end
    if (start && !b_reg.pin_s2.rw) begin
      if (b_reg.pin_s2.reg_b_sel) begin
        b_next.mailbox_high_byte = b_reg.pin_s2.data_in;
      end else begin
        b_next.mailbox_low_byte = b_reg.pin_s2.data_in;
      end
    end
    if (start && upper) begin
      b_next.busy = 1'b1;
      b_next.req_toggle = !b_reg.req_toggle;
      b_next.req_word = {b_next.mailbox_high_byte, b_next.mailbox_low_byte};
      b_next.req_cmd = b_reg.pin_s2.cmd_xfer_sel;
      b_next.req_read = b_reg.pin_s2.rw;
    end
    b_next.req_strobe_n = !(sel && upper);
  end

  always_ff @(posedge bus_clock or negedge resetn) begin
    if (!resetn) begin
      b_reg <= '0;
      b_reg.pin_s1.cs_n <= 1'b1;
      b_reg.pin_s2.cs_n <= 1'b1;
      b_reg.req_strobe_n <= 1'b1;
    end else begin
      b_reg <= b_next;
    end
  end

  assign data_out = b_reg.data_out;
  assign data_oe = b_reg.data_oe;
  assign request_strobe_n = b_reg.req_strobe_n;

  // timing side domain, runs on the system clock

  assign push = (c_reg.state == SVC_IDLE) && c_reg.pending && bus_grant && buf_in_ready;
  assign push_entry.word = c_reg.pend_word;
  assign push_entry.kind = c_reg.pend_cmd ? ENTRY_CMD :
                           (c_reg.pend_read ? ENTRY_READ : ENTRY_WRITE);
  assign fill_ready = (c_reg.state == SVC_WAIT_FILL);

  always_comb begin
    c_next = c_reg;
    c_next.req_s1 = b_reg.req_toggle;
    c_next.req_s2 = c_reg.req_s1;
    c_next.req_seen = c_reg.req_s2;
    c_next.restart_s1 = restart_n;
    c_next.restart_s2 = c_reg.restart_s1;
    req_edge = (c_reg.req_s2 != c_reg.req_seen);
    c_next.mbox_cycle_n = 1'b1;
    c_next.internal_dir = 1'b1;
    unique case (c_reg.state)
      SVC_IDLE: begin
        if (push) begin
          c_next.mbox_cycle_n = 1'b0;
          c_next.internal_dir = 1'b0;
          c_next.pending = 1'b0;
          if (c_reg.pend_cmd) begin
            if (c_reg.pend_word[`OPCODE_MSB:`OPCODE_LSB] == `OPCODE_LOAD_MODE) begin
              c_next.hold_high = 1'b0;
            end
          end
          if (!c_reg.pend_cmd && c_reg.pend_read) begin
            c_next.state = SVC_WAIT_FILL;
          end else begin
            c_next.ack_load = 1'b0;
            c_next.ack_toggle = !c_reg.ack_toggle;
          end
        end
      end
      SVC_WAIT_FILL: begin
        if (fill_valid) begin
          c_next.mbox_cycle_n = 1'b0;
          c_next.internal_dir = 1'b1;
          c_next.ack_word = fill_word;
          c_next.ack_load = 1'b1;
          c_next.ack_toggle = !c_reg.ack_toggle;
          c_next.state = SVC_IDLE;
        end
      end
    endcase
    if (req_edge) begin
      c_next.pending = 1'b1;
      c_next.pend_cmd = b_reg.req_cmd;
      c_next.pend_read = b_reg.req_read;
      c_next.pend_word = b_reg.req_word;
    end
    if (!c_reg.restart_s2) begin
      c_next.hold_high = 1'b1;
    end
    c_next.hsync = c_next.hold_high || line_sync_raw;
    if (!chargen_strobe_n && (slice_addr <= `SLICE_MAX)) begin
      c_next.slice_index = slice_addr;
      c_next.slice_valid = 1'b1;
    end else begin
      c_next.slice_valid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      c_reg <= '0;
      c_reg.restart_s1 <= 1'b1;
      c_reg.restart_s2 <= 1'b1;
      c_reg.hold_high <= 1'b1;
      c_reg.hsync <= 1'b1;
      c_reg.mbox_cycle_n <= 1'b1;
      c_reg.internal_dir <= 1'b1;
      c_reg.state <= SVC_IDLE;
    end else begin
      c_reg <= c_next;
    end
  end

  assign hsync_out = c_reg.hsync;
  assign mbox_cycle_n = c_reg.mbox_cycle_n;
  assign internal_dir = c_reg.internal_dir;
  assign slice_index = c_reg.slice_index;
  assign slice_valid = c_reg.slice_valid;

  // a stalled access automaton holds requests here and blocks further service
  two_entry_buffer u_buffer (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_entry  (push_entry),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_entry (word_out)
  );

endmodule

// ==== tb/mbox_port_asserts.sv ====
`timescale 1ns/100ps
module mbox_port_asserts (
  // clocks and reset
  input wire logic               clock,
  input wire logic               bus_clock,
  input wire logic               resetn,
  // processor side
  input wire mbox_pkg::cpu_bus_t cpu_in,
  input wire logic [7:0]         data_out,
  input wire logic               data_oe,
  input wire logic               request_strobe_n,
  // timing side
  input wire logic               restart_n,
  input wire logic               hsync_out,
  input wire logic               mbox_cycle_n,
  input wire logic               internal_dir,
  input wire logic               fill_ready,
  input wire logic               word_valid,
  input wire logic               word_ready,
  input wire mbox_pkg::entry_t   word_out,
  input wire logic               chargen_strobe_n,
  input wire logic [3:0]         slice_addr,
  input wire logic [3:0]         slice_index,
  input wire logic               slice_valid
);
  import mbox_pkg::*;
  sequence s_restart_held;
    $fell(restart_n) ##1 !restart_n [*6];
  endsequence
  sequence s_upper_start;
    $rose(!cpu_in.cs_n && cpu_in.enable && cpu_in.reg_b_sel
          && !(cpu_in.rw && cpu_in.cmd_xfer_sel));
  endsequence
  a_oe_read_only: assert property (@(posedge bus_clock) disable iff (!resetn)
    data_oe |-> $past(cpu_in.rw && !(cpu_in.cmd_xfer_sel && cpu_in.reg_b_sel), 2))
    else $error("data pins driven outside a legal read");
  a_oe_release: assert property (@(posedge bus_clock) disable iff (!resetn)
    $fell(cpu_in.enable) |-> ##[1:5] !data_oe)
    else $error("data pins still driven after enable fell");
  a_strobe_upper: assert property (@(posedge bus_clock) disable iff (!resetn)
    !request_strobe_n |-> $past(cpu_in.reg_b_sel, 2))
    else $error("request strobe without upper register access");
  a_strobe_raised: assert property (@(posedge bus_clock) disable iff (!resetn)
    s_upper_start |-> ##[1:5] !request_strobe_n)
    else $error("upper access gave no request strobe");
  a_busy_only_bit: assert property (@(posedge bus_clock) disable iff (!resetn)
    data_oe && $past(cpu_in.cmd_xfer_sel, 2) |-> data_out[6:0] == 7'h00)
    else $error("status read carries more than the busy bit");
  a_restart_hsync: assert property (@(posedge clock) disable iff (!resetn)
    s_restart_held |-> hsync_out)
    else $error("line sync not forced high by restart");
  a_word_hold: assert property (@(posedge clock) disable iff (!resetn)
    word_valid && !word_ready |=> word_valid && $stable(word_out))
    else $error("request word lost during stall");
  a_mbox_pulse: assert property (@(posedge clock) disable iff (!resetn)
    !mbox_cycle_n |=> mbox_cycle_n)
    else $error("mailbox cycle strobe longer than one cycle");
  a_dir_source: assert property (@(posedge clock) disable iff (!resetn)
    !mbox_cycle_n && !internal_dir |-> word_valid)
    else $error("mailbox read as source without a buffered request word");
  a_dir_dest: assert property (@(posedge clock) disable iff (!resetn)
    !mbox_cycle_n && internal_dir |-> $past(fill_ready))
    else $error("mailbox written as destination without a pending fill");
  a_slice_take: assert property (@(posedge clock) disable iff (!resetn)
    !chargen_strobe_n && slice_addr <= 4'h9 |=> slice_valid && slice_index == $past(slice_addr))
    else $error("slice index not captured");
endmodule
bind display_mailbox_host_port mbox_port_asserts i_mbox_port_asserts (.*);

// ==== tb/access_side_model.sv ====
`timescale 1ns/100ps
module access_side_model (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // bench control and observation
  input  wire logic             stall,
  output mbox_pkg::entry_t      got,
  output logic [7:0]            n_got,
  // request stream
  input  wire logic             word_valid,
  output logic                  word_ready,
  input  wire mbox_pkg::entry_t word_out,
  // read transfer return
  input  wire logic             fill_ready,
  output logic                  fill_valid,
  output logic [15:0]           fill_word
);
  import mbox_pkg::*;
  assign word_ready = !stall;
  assign fill_word = fill_valid ? 16'h5AC3 : 16'hA53C;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fill_valid <= 1'b0;
      n_got      <= 8'h00;
      got        <= '0;
    end else begin
      if (word_valid && word_ready) begin
        got   <= word_out;
        n_got <= n_got + 8'h01;
      end
      fill_valid <= fill_ready && !fill_valid;
    end
  end
endmodule

// ==== tb/display_mailbox_host_port_test.sv ====
`timescale 1ns/100ps
module display_mailbox_host_port_test;
  import mbox_pkg::*;
  logic        clock, bus_clock, resetn, restart_n, line_sync_raw, bus_grant, stall;
  logic        data_oe, request_strobe_n, hsync_out, mbox_cycle_n, internal_dir, strobe_seen, oe;
  logic        word_valid, word_ready, fill_valid, fill_ready, chargen_strobe_n, slice_valid;
  logic [7:0]  data_out, q, n_got;
  logic [15:0] fill_word;
  logic [3:0]  slice_addr, slice_index;
  cpu_bus_t    cpu_in;
  entry_t      word_out, got;
  int          bad_count, n_tests;

  display_mailbox_host_port i_display_mailbox_host_port (
    .clock, .bus_clock, .resetn, .cpu_in, .data_out, .data_oe, .request_strobe_n,
    .restart_n, .line_sync_raw, .hsync_out, .bus_grant, .mbox_cycle_n, .internal_dir,
    .word_valid, .word_ready, .word_out, .fill_valid, .fill_word, .fill_ready,
    .chargen_strobe_n, .slice_addr, .slice_index, .slice_valid);
  access_side_model i_access_side_model (
    .clock, .resetn, .stall, .got, .n_got, .word_valid, .word_ready, .word_out,
    .fill_ready, .fill_valid, .fill_word);

  always #12.5 clock = ~clock;
  always #6 bus_clock = ~bus_clock;

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [17:0] g, input logic [17:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one enable pulse; strobe and read data observed while selected
  task acc(input logic r, c, b, input logic [7:0] d);
    cpu_in = '{1'b0, 1'b1, r, b, c, d};
    strobe_seen = 1'b0;
    oe = 1'b0;
    q = 8'hFF;
    repeat (6) begin
      @(negedge clock);
      if (request_strobe_n === 1'b0) strobe_seen = 1'b1;
      if (data_oe === 1'b1) begin
        oe = 1'b1;
        q = data_out;
      end
    end
    cpu_in = '{1'b1, 1'b0, r, b, c, ~d};
    repeat (5) @(negedge clock);
  endtask

  task ww(input logic [7:0] k);
    repeat (80) begin
      if (n_got !== k) @(negedge clock);
    end
  endtask

  initial begin
    #400000;
    bad_count++;
    end_sim;
  end

  initial begin
    clock = 1'b0;
    bus_clock = 1'b0;
    resetn = 1'b0;
    restart_n = 1'b1;
    line_sync_raw = 1'b0;
    bus_grant = 1'b0;
    stall = 1'b1;
    chargen_strobe_n = 1'b1;
    slice_addr = 4'h0;
    cpu_in = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00};
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    chk(hsync_out, 1'h1);
    chk(data_oe, 1'h0);
    repeat (2560) @(negedge clock);
    acc(1'b0, 1'b1, 1'b0, 8'h00);
    chk({strobe_seen, oe}, 2'h0);
    acc(1'b0, 1'b1, 1'b1, 8'hA0);
    chk(strobe_seen, 1'h1);
    acc(1'b1, 1'b1, 1'b0, 8'h00);
    chk(q, 8'h80);
    acc(1'b1, 1'b1, 1'b1, 8'h00);
    chk({strobe_seen, oe}, 2'h0);
    chk(n_got, 8'h00);
    bus_grant = 1'b1;
    stall = 1'b0;
    ww(8'h01);
    chk(got, {ENTRY_CMD, 16'hA000});
    acc(1'b1, 1'b1, 1'b0, 8'h00);
    chk(q, 8'h00);
    chk(hsync_out, 1'h0);
    // line sync passes through once the hold is gone
    line_sync_raw = 1'b1;
    repeat (2) @(negedge clock);
    chk(hsync_out, 1'h1);
    line_sync_raw = 1'b0;
    restart_n = 1'b0;
    repeat (10) @(negedge clock);
    chk(hsync_out, 1'h1);
    restart_n = 1'b1;
    // a command other than the mode load keeps the hold
    acc(1'b0, 1'b1, 1'b1, 8'h80);
    ww(8'h02);
    chk(got, {ENTRY_CMD, 16'h8000});
    chk(hsync_out, 1'h1);
    acc(1'b0, 1'b0, 1'b0, 8'h3C);
    acc(1'b0, 1'b0, 1'b1, 8'h96);
    chk({strobe_seen, oe}, 2'h2);
    ww(8'h03);
    chk(got, {ENTRY_WRITE, 16'h963C});
    acc(1'b1, 1'b0, 1'b1, 8'h00);
    chk(q, 8'h96);
    ww(8'h04);
    chk(got.kind, ENTRY_READ);
    repeat (8) @(negedge clock);
    acc(1'b1, 1'b0, 1'b0, 8'h00);
    chk(q, 8'hC3);
    stall = 1'b1;
    acc(1'b0, 1'b0, 1'b1, 8'h11);
    acc(1'b0, 1'b0, 1'b1, 8'h22);
    acc(1'b0, 1'b0, 1'b1, 8'h33);
    chk(n_got, 8'h04);
    stall = 1'b0;
    ww(8'h07);
    chk(n_got, 8'h07);
    chk(got, {ENTRY_WRITE, 16'h33C3});
    chargen_strobe_n = 1'b0;
    slice_addr = 4'h9;
    repeat (2) @(negedge clock);
    chk({slice_valid, slice_index}, 5'h19);
    slice_addr = 4'hC;
    repeat (2) @(negedge clock);
    chk(slice_index, 4'h9);
    chargen_strobe_n = 1'b1;
    end_sim;
  end
endmodule
